// ==== hw/oom_mode_ctl.sv ====
// mode, direction and carrier gating logic of the coax modem, with its skew fifo
// Notes on behaviour
// (R1) both rate selects high enters standby
// (R2) standby: receive works, carrier output quiet
// (R3) start in idle; rx high, quiet, enable low
// (R4) idle to receive on valid carrier
// (R5) idle to transmit when tx bit low
// (R6) receive: rx output follows any valid carrier
// (R7) rx/tx modes: carrier out while tx low
// (R8) receive ends 16 bits after last rise
// (R9) transmit: rx output held high
// (R10) transmit ends 16 bits after tx rise
// (R11) timeout 1667us slow, 417us fast
// (R12) driver quiet when tx high
// (R13) idle: rx high, enable low
// (R14) receive: filtered carrier gives rx low, enable high
// (R15) receive gap: rx high, enable high
// (R16) transmit: enable low, rx high
// (R17) enable leads rx change by 270ns
// (R18) standby takes effect after 2ms
// (R19) noise filter 2us fast, 4us slow
// (R20) open selects give longest timeout
// (R21) timeout counter restarts on activity
// (R22) local logic keeps tx high in receive
`timescale 1ns/1ps
`include "oom_defines.svh"

module oom_fifo #(
	parameter int WIDTH = `OOM_FIFO_W,
	parameter int DEPTH = `OOM_FIFO_DEPTH,
	parameter int CW = $clog2(DEPTH + 1)
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [CW-1:0] count
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
	logic [CW-1:0] cnt_ff, nxt_cnt;
	logic push, pop;

	// honest flags straight from the fill count
	always_comb begin
		in_ready = (cnt_ff != CW'(DEPTH));
		out_valid = (cnt_ff != '0);
		out_data = mem_ff[rd_ff];
		count = cnt_ff;
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		nxt_wr = push ? AW'((32'(wr_ff) + 1) % DEPTH) : wr_ff;
		nxt_rd = pop ? AW'((32'(rd_ff) + 1) % DEPTH) : rd_ff;
		nxt_cnt = cnt_ff + CW'(push) - CW'(pop);
	end

	// storage has no reset; only pointers and count need a defined value
	always_ff @(posedge clk) begin
		if (push) begin
			mem_ff[wr_ff] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
		end else begin
			wr_ff <= nxt_wr;
			rd_ff <= nxt_rd;
			cnt_ff <= nxt_cnt;
		end
	end
endmodule : oom_fifo

module oom_mode_ctl
	import oom_pkg::*;
#(
	parameter int DIR_SLOW_CYC = `OOM_DIR_SLOW_US * (`OOM_CLK_HZ / `OOM_US_PER_S),
	parameter int DIR_FAST_CYC = `OOM_DIR_FAST_US * (`OOM_CLK_HZ / `OOM_US_PER_S),
	parameter int STBY_CYC = `OOM_STBY_EN_US * (`OOM_CLK_HZ / `OOM_US_PER_S)
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire oom_pkg::oom_rate_t rate_sel,
	input wire logic tx_bit_in,
	input wire logic carrier_in,
	output logic carrier_out,
	output logic rx_bit_out,
	output logic bus_drive_enable,
	output oom_pkg::oom_state_t mode
);
	import oom_pkg::*;

	localparam int NF_FAST = `OOM_NF_FAST_NS / `OOM_CLK_NS;
	localparam int NF_SLOW = `OOM_NF_SLOW_NS / `OOM_CLK_NS;
	// least time, so round up
	localparam int SKEW_CYC = (`OOM_SKEW_NS + `OOM_CLK_NS - 1) / `OOM_CLK_NS;
	localparam logic [63:0] NCO_INC64 =
		(64'(`OOM_CARRIER_HZ) << `OOM_NCO_W) / 64'(`OOM_CLK_HZ);
	localparam logic [`OOM_NCO_W-1:0] NCO_INC = NCO_INC64[`OOM_NCO_W-1:0];
	localparam int CW = $clog2(`OOM_FIFO_DEPTH + 1);

	// fast rate: select a high, b low; open or low gives slow
	function automatic logic sel_fast(input oom_rate_t r);
		sel_fast = r.rate_select_a && !r.rate_select_b;
	endfunction : sel_fast

	// pin synchronisers, first stage read only by the second
	oom_rate_t rs1_ff, rs_ff;
	logic tx1_ff, tx_ff, cin1_ff, cin_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rs1_ff <= '0;
			rs_ff <= '0;
			tx1_ff <= 1'b1;
			tx_ff <= 1'b1;
			cin1_ff <= 1'b0;
			cin_ff <= 1'b0;
		end else begin
			rs1_ff <= rate_sel;
			rs_ff <= rs1_ff;
			tx1_ff <= tx_bit_in;
			tx_ff <= tx1_ff;
			cin1_ff <= carrier_in;
			cin_ff <= cin1_ff;
		end
	end

	logic fast;
	logic stby_req;
	assign fast = sel_fast(rs_ff); // R20
	assign stby_req = rs_ff.rate_select_a && rs_ff.rate_select_b; // R1

	// carrier qualification: must persist past the noise filter
	logic [`OOM_NF_W-1:0] nf_ff, nxt_nf, nf_len;
	logic det;

	always_comb begin
		nf_len = fast ? `OOM_NF_W'(NF_FAST) : `OOM_NF_W'(NF_SLOW); // R19
		det = (nf_ff >= nf_len);
		nxt_nf = nf_ff;
		if (!cin_ff) begin
			nxt_nf = '0;
		end else if (!det) begin
			nxt_nf = nf_ff + `OOM_NF_W'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			nf_ff <= '0;
		end else begin
			nf_ff <= nxt_nf;
		end
	end

	// delay the demodulated bit so the enable leads it in receive mode
	logic f_in_ready, f_out_valid, f_out_ready;
	logic [`OOM_FIFO_W-1:0] f_out;
	logic [CW-1:0] f_count;

	assign f_out_ready = (f_count >= CW'(SKEW_CYC)); // R17

	oom_fifo #(
		.WIDTH(`OOM_FIFO_W),
		.DEPTH(`OOM_FIFO_DEPTH)
	) u_skew (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(1'b1),
		.in_ready(f_in_ready),
		.in_data(`OOM_FIFO_W'(!det)), // R6 R14
		.out_valid(f_out_valid),
		.out_ready(f_out_ready),
		.out_data(f_out),
		.count(f_count)
	);

	// mode machine with standby qualify and direction timers
	oom_state_t state_ff, nxt_state;
	logic [`OOM_CNT_W-1:0] dir_ff, nxt_dir, stby_ff, nxt_stby, dir_len;
	logic stby_go, dir_zero;

	always_comb begin
		dir_len = fast ? `OOM_CNT_W'(DIR_FAST_CYC - 1) :
			`OOM_CNT_W'(DIR_SLOW_CYC - 1); // R11 R20
		dir_zero = (dir_ff == '0);
		stby_go = stby_req && (stby_ff == `OOM_CNT_W'(STBY_CYC - 1)); // R18
		nxt_stby = stby_req ? (stby_go ? stby_ff : stby_ff + `OOM_CNT_W'(1)) : '0;
		nxt_state = state_ff;
		nxt_dir = dir_zero ? dir_ff : dir_ff - `OOM_CNT_W'(1);
		unique case (state_ff)
			OOM_STANDBY: begin
				if (!stby_req) begin
					nxt_state = OOM_IDLE;
				end
			end
			OOM_IDLE: begin
				if (stby_go) begin
					nxt_state = OOM_STANDBY; // R1
				end else if (det) begin
					nxt_state = OOM_RECEIVE; // R4
					nxt_dir = dir_len;
				end else if (!tx_ff) begin
					nxt_state = OOM_TRANSMIT; // R5
					nxt_dir = dir_len;
				end
			end
			OOM_RECEIVE: begin
				if (det) begin
					nxt_dir = dir_len; // R21
				end else if (dir_zero) begin
					nxt_state = OOM_IDLE; // R8
				end
			end
			OOM_TRANSMIT: begin
				if (!tx_ff) begin
					nxt_dir = dir_len; // R21
				end else if (dir_zero) begin
					nxt_state = OOM_IDLE; // R10
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= OOM_IDLE; // R3
			dir_ff <= '0;
			stby_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			dir_ff <= nxt_dir;
			stby_ff <= nxt_stby;
		end
	end

	// carrier phase accumulator, msb is the square carrier
	logic [`OOM_NCO_W-1:0] ph_ff, nxt_ph;
	logic [`OOM_NF_W-1:0] lead_ff, nxt_lead;
	logic nxt_cout, nxt_rx, nxt_den;

	always_comb begin
		nxt_ph = ph_ff + NCO_INC;
		// cycles since the enable rose, saturating at the skew count
		nxt_lead = '0;
		if (nxt_state == OOM_RECEIVE) begin
			nxt_lead = (lead_ff == `OOM_NF_W'(SKEW_CYC)) ? lead_ff : lead_ff + `OOM_NF_W'(1);
		end
		// driver only in receive or transmit and only for a zero
		nxt_cout = ph_ff[`OOM_NCO_W-1] && !tx_ff &&
			(nxt_state == OOM_RECEIVE || nxt_state == OOM_TRANSMIT); // R2 R7 R12
		nxt_den = (nxt_state == OOM_RECEIVE); // R13 R14 R15 R16
		nxt_rx = 1'b1; // R9 R13
		if (nxt_state == OOM_RECEIVE || nxt_state == OOM_STANDBY) begin
			nxt_rx = (f_out_valid && f_out_ready) ? f_out[0] : rx_bit_out; // R2 R6
		end
		// stale zeros left in the fifo by transmit or standby must not
		// reach rx before the enable has led it
		if (nxt_state == OOM_RECEIVE && lead_ff < `OOM_NF_W'(SKEW_CYC)) begin
			nxt_rx = 1'b1; // R17
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ph_ff <= '0;
			lead_ff <= '0;
			carrier_out <= 1'b0;
			rx_bit_out <= 1'b1;
			bus_drive_enable <= 1'b0;
		end else begin
			ph_ff <= nxt_ph;
			lead_ff <= nxt_lead;
			carrier_out <= nxt_cout;
			rx_bit_out <= nxt_rx;
			bus_drive_enable <= nxt_den;
		end
	end

	assign mode = state_ff;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	AST_STBY_ENTRY: assert property ( // R1
		(state_ff == OOM_IDLE && stby_go) |=> state_ff == OOM_STANDBY)
		else $error("standby not entered");
	AST_STBY_QUIET: assert property ( // R2
		(state_ff == OOM_STANDBY)[*2] |-> !carrier_out && !bus_drive_enable)
		else $error("carrier or enable active in standby");
	AST_IDLE_OUT: assert property ( // R3
		(state_ff == OOM_IDLE)[*2] |-> rx_bit_out && !bus_drive_enable && !carrier_out)
		else $error("idle outputs wrong");
	AST_IDLE_TO_RX: assert property ( // R4
		(state_ff == OOM_IDLE && det && !stby_go) |=> state_ff == OOM_RECEIVE && bus_drive_enable)
		else $error("valid carrier did not start receive");
	AST_IDLE_TO_TX: assert property ( // R5
		(state_ff == OOM_IDLE && !det && !tx_ff && !stby_go) |=> state_ff == OOM_TRANSMIT)
		else $error("low tx bit did not start transmit");
	AST_TX_QUIET: assert property ( // R7
		(state_ff == OOM_TRANSMIT && tx_ff) |=> !carrier_out)
		else $error("carrier sent while tx bit high");
	AST_RX_END: assert property ( // R8
		(state_ff == OOM_RECEIVE && !det && dir_zero) |=> state_ff == OOM_IDLE)
		else $error("receive did not time out");
	AST_TX_HOLD: assert property ( // R9
		(state_ff == OOM_TRANSMIT)[*2] |-> rx_bit_out && !bus_drive_enable)
		else $error("rx not held high in transmit");
	AST_TX_RESTART: assert property ( // R10
		(state_ff == OOM_TRANSMIT && !tx_ff) |=> dir_ff == $past(dir_len))
		else $error("transmit timer not restarted");
	AST_SKEW: assert property ( // R17
		$rose(bus_drive_enable) |-> rx_bit_out[*8])
		else $error("rx changed too soon after enable");
endmodule : oom_mode_ctl

// ==== hw/oom_defines.svh ====
// timing and layout constants for the coax modem mode control
`ifndef OOM_DEFINES_SVH
`define OOM_DEFINES_SVH
`define OOM_CLK_HZ 40000000
`define OOM_CLK_NS 25
`define OOM_CARRIER_HZ 2176000
`define OOM_NCO_W 24
`define OOM_NF_FAST_NS 2000
`define OOM_NF_SLOW_NS 4000
`define OOM_DIR_SLOW_US 1667
`define OOM_DIR_FAST_US 417
`define OOM_STBY_EN_US 2000
`define OOM_SKEW_NS 270
`define OOM_FIFO_DEPTH 32
`define OOM_FIFO_W 1
`define OOM_CNT_W 20
`define OOM_NF_W 8
`define OOM_US_PER_S 1000000
`endif

// ==== hw/oom_pkg.sv ====
// types shared by the coax modem mode control
package oom_pkg;
	// operating modes, one-hot
	typedef enum logic [3:0] {
		OOM_STANDBY = 4'h1,
		OOM_IDLE = 4'h2,
		OOM_RECEIVE = 4'h4,
		OOM_TRANSMIT = 4'h8
	} oom_state_t;
	// the two rate select straps travel together
	typedef struct packed {
		logic rate_select_a;
		logic rate_select_b;
	} oom_rate_t;
endpackage : oom_pkg

// ==== bench/oom_remote_modem.sv ====
// far side coax modem model: drives the carrier envelope seen at carrier_in
`timescale 1ns/1ps
module oom_remote_modem (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic send_zero,
	output logic carrier_in
);
	// envelope above threshold only while a zero bit is on the coax
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			carrier_in <= 1'b0;
		end else begin
			carrier_in <= send_zero;
		end
	end
endmodule : oom_remote_modem

// ==== bench/test_oom_mode_ctl.sv ====
// self-checking bench for the coax modem mode control
`timescale 1ns/1ps
module test_oom_mode_ctl;
	import oom_pkg::*;
	typedef struct packed {
		oom_state_t mode;
		logic rx;
		logic bde;
	} oom_snap_t;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	oom_rate_t rate_sel = '0;
	logic tx_bit_in = 1'b1;
	logic send_zero = 1'b0;
	logic carrier_in, carrier_out, rx_bit_out, bus_drive_enable;
	oom_state_t mode;
	oom_snap_t expq[$];
	oom_snap_t e;
	logic prev_co = 1'b0;
	int tog = 0;
	int hi = 0;
	int error_cnt = 0;
	int checks = 0;
	int seed = 52;
	int n;
	always #12.5 clk = ~clk;
	// short timeouts keep the run small; expectations below follow them
	oom_mode_ctl #(.DIR_SLOW_CYC(200), .DIR_FAST_CYC(100), .STBY_CYC(50)) dut (
		.clk(clk), .rst_n(rst_n), .rate_sel(rate_sel), .tx_bit_in(tx_bit_in),
		.carrier_in(carrier_in), .carrier_out(carrier_out), .rx_bit_out(rx_bit_out),
		.bus_drive_enable(bus_drive_enable), .mode(mode));
	oom_remote_modem remote (.clk(clk), .rst_n(rst_n), .send_zero(send_zero),
		.carrier_in(carrier_in));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic close_out();
		if (error_cnt == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : close_out
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask : cyc
	task automatic snap(input oom_state_t m, input logic rx, input logic bde);
		expq.push_back('{m, rx, bde});
	endtask : snap
	// oldest note against outputs settled half a cycle after the edge
	always @(negedge clk) begin
		if (expq.size() > 0) begin
			e = expq.pop_front();
			chk({mode, rx_bit_out, bus_drive_enable, 2'b00}, {e, 2'b00});
		end
	end
	// carrier activity counters, read by the driver at rising edges
	always @(negedge clk) begin
		if (carrier_out !== prev_co) tog++;
		if (carrier_out !== 1'b0) hi++;
		prev_co = carrier_out;
	end
	initial begin
		#75000;
		error_cnt++;
		close_out();
	end
	initial begin
		cyc(8);
		rst_n <= 1'b1;
		cyc(4);
		snap(OOM_IDLE, 1'b1, 1'b0);
		chk(8'(hi), 8'h00);
		// slow rate: a burst shorter than the slow filter stays idle
		send_zero <= 1'b1;
		cyc(120);
		snap(OOM_IDLE, 1'b1, 1'b0);
		send_zero <= 1'b0;
		// let the filter count clear before the faster rate takes over
		cyc(10);
		rate_sel <= '{1'b1, 1'b0};
		cyc(10);
		// fast rate zero bit of random length; local tx kept high meanwhile
		n = 110 + ($random(seed) & 31);
		send_zero <= 1'b1;
		cyc(100);
		snap(OOM_RECEIVE, 1'b0, 1'b1);
		cyc(n - 100);
		send_zero <= 1'b0;
		cyc(80);
		snap(OOM_RECEIVE, 1'b1, 1'b1);
		cyc(40);
		snap(OOM_IDLE, 1'b1, 1'b0);
		// transmit with a carrier on the coax that must be ignored
		tog = 0;
		tx_bit_in <= 1'b0;
		send_zero <= 1'b1;
		cyc(6);
		snap(OOM_TRANSMIT, 1'b1, 1'b0);
		cyc(100);
		snap(OOM_TRANSMIT, 1'b1, 1'b0);
		chk(8'(tog > 3), 8'h01);
		tx_bit_in <= 1'b1;
		send_zero <= 1'b0;
		cyc(6);
		hi = 0;
		cyc(80);
		chk(8'(hi), 8'h00);
		snap(OOM_TRANSMIT, 1'b1, 1'b0);
		cyc(40);
		snap(OOM_IDLE, 1'b1, 1'b0);
		// standby: receiver still works, driver stays quiet
		rate_sel <= '{1'b1, 1'b1};
		cyc(60);
		snap(OOM_STANDBY, 1'b1, 1'b0);
		hi = 0;
		tx_bit_in <= 1'b0;
		send_zero <= 1'b1;
		// standby uses the slow filter, so the zero shows late
		cyc(200);
		snap(OOM_STANDBY, 1'b0, 1'b0);
		chk(8'(hi), 8'h00);
		tx_bit_in <= 1'b1;
		send_zero <= 1'b0;
		cyc(20);
		rate_sel <= '{1'b0, 1'b0};
		cyc(6);
		snap(OOM_IDLE, 1'b1, 1'b0);
		cyc(3);
		close_out();
	end
endmodule : test_oom_mode_ctl
